/* File: stream_shim_pkg.sv */
// constants used by the stream/framing shim; its register slice takes its width and polarities only as parameters
// assumes a single user clock and a synchronous active-high reset
package stream_shim_pkg;

  // user data path: bytes per word
  localparam int DATA_BYTES = 8;
  localparam int DATA_W = DATA_BYTES * 8;
  localparam int REMAINDER_W = $clog2(DATA_BYTES);

  // user flow control path: bytes per word
  localparam int UFC_BYTES = 8;
  localparam int UFC_W = UFC_BYTES * 8;
  localparam int UFC_REMAINDER_W = $clog2(UFC_BYTES);

  // native flow control stream word layout
  localparam int NFC_PAUSE_W = 8;
  localparam int NFC_PAUSE_POS = 0;
  localparam int NFC_STOP_POS = 8;
  localparam int NFC_DATA_W = 16;

  // user control stream word layout
  localparam int UK_PAY_W = 56;
  localparam int UK_PAY_POS = 0;
  localparam int UK_BLK_W = 4;
  localparam int UK_BLK_POS = 56;
  localparam int UK_DATA_W = 64;

  // values held during reset
  localparam logic RST_ACTIVE_LOW_IDLE = 1'b1;
  localparam logic RST_ACTIVE_HIGH_IDLE = 1'b0;
  localparam logic RST_IN_FRAME = 1'b0;

endpackage : stream_shim_pkg

/* File: frame_slice.sv */
// one-word register slice with a skid word, polarity set per side
// assumes in_valid and out_ready are synchronous to clk
`timescale 1ns/1ps
module frame_slice #(
  parameter int W = 8,
  parameter bit IN_LOW = 1'b0,
  parameter bit OUT_LOW = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] main_q;
  logic [W-1:0] skid_q;
  logic out_valid_q;
  logic in_ready_q;
  logic main_vld;
  logic skid_vld;
  logic in_vld;
  logic out_rdy;
  logic take;
  logic free;

  if (W < 1) begin : g_chk
    $error("frame_slice width must be at least one");
  end

  // internal handshake is active high
  assign main_vld = out_valid_q ^ OUT_LOW;
  assign skid_vld = ~(in_ready_q ^ IN_LOW);
  assign in_vld = in_valid ^ IN_LOW;
  assign out_rdy = out_ready ^ OUT_LOW;
  assign take = in_vld & ~skid_vld;
  assign free = ~main_vld | out_rdy;

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_q <= OUT_LOW;
      main_q <= '0;
    end else if (free) begin
      if (skid_vld) begin
        main_q <= skid_q;
        out_valid_q <= ~OUT_LOW;
      end else begin
        out_valid_q <= take ^ OUT_LOW;
        if (take) begin
          main_q <= in_data;
        end
      end
    end
  end

  // skid word absorbs one transfer while output stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      in_ready_q <= ~IN_LOW;
      skid_q <= '0;
    end else if (free) begin
      in_ready_q <= ~IN_LOW;
    end else if (take) begin
      skid_q <= in_data;
      in_ready_q <= IN_LOW;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = main_q;

endmodule : frame_slice

/* File: stream_framing_shim.sv */
// stream to framing shims for data, user flow control, native flow control
// and user control, plus framing to stream shims for data and user flow control
// assumes both sides run on clk and share the core reset
`timescale 1ns/1ps
module stream_framing_shim
  import stream_shim_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // user data, stream side in
  input wire logic [stream_shim_pkg::DATA_W-1:0] s_axis_tx_tdata,
  input wire logic [stream_shim_pkg::DATA_BYTES-1:0] s_axis_tx_tkeep,
  input wire logic s_axis_tx_tlast,
  input wire logic s_axis_tx_tvalid,
  output logic s_axis_tx_tready,
  // user data, framing side out
  output logic [stream_shim_pkg::DATA_W-1:0] tx_data,
  output logic [stream_shim_pkg::REMAINDER_W-1:0] tx_remainder_count,
  output logic tx_sof_n,
  output logic tx_eof_n,
  output logic tx_src_ready_n,
  input wire logic tx_dest_ready_n,
  // user flow control, stream side in
  input wire logic ufc_tx_req,
  input wire logic [7:0] ufc_tx_ms,
  input wire logic [stream_shim_pkg::UFC_W-1:0] s_axis_ufc_tx_tdata,
  input wire logic s_axis_ufc_tx_tvalid,
  output logic s_axis_ufc_tx_tready,
  // user flow control, framing side out
  output logic ufc_tx_req_n,
  output logic [7:0] ufc_tx_ms_q,
  output logic [stream_shim_pkg::UFC_W-1:0] ufc_tx_data,
  output logic ufc_tx_src_ready_n,
  input wire logic ufc_tx_dest_ready_n,
  // native flow control, stream side in
  input wire logic [stream_shim_pkg::NFC_DATA_W-1:0] s_axis_nfc_tx_tdata,
  input wire logic s_axis_nfc_tx_tvalid,
  output logic s_axis_nfc_tx_tready,
  // native flow control, framing side out
  output logic [stream_shim_pkg::NFC_PAUSE_W-1:0] nfc_pause_count,
  output logic flow_stop_request,
  output logic nfc_tx_req_n,
  input wire logic nfc_tx_ack_n,
  // user control, stream side in
  input wire logic [stream_shim_pkg::UK_DATA_W-1:0] s_axis_user_k_tdata,
  input wire logic s_axis_user_k_tvalid,
  output logic s_axis_user_k_tready,
  // user control, framing side out
  output logic [stream_shim_pkg::UK_PAY_W-1:0] user_k_data,
  output logic [stream_shim_pkg::UK_BLK_W-1:0] user_block_number,
  output logic user_k_src_ready_n,
  input wire logic user_k_dest_ready_n,
  // user data receive, framing side in
  input wire logic [stream_shim_pkg::DATA_W-1:0] rx_data,
  input wire logic [stream_shim_pkg::REMAINDER_W-1:0] rx_remainder_count,
  input wire logic rx_eof_n,
  input wire logic rx_src_ready_n,
  // user data receive, stream side out
  output logic [stream_shim_pkg::DATA_W-1:0] m_axis_rx_tdata,
  output logic [stream_shim_pkg::DATA_BYTES-1:0] m_axis_rx_tkeep,
  output logic m_axis_rx_tlast,
  output logic m_axis_rx_tvalid,
  // user flow control receive, framing side in
  input wire logic [stream_shim_pkg::UFC_W-1:0] ufc_rx_data,
  input wire logic [stream_shim_pkg::UFC_REMAINDER_W-1:0] ufc_rx_remainder_count,
  input wire logic ufc_rx_eof_n,
  input wire logic ufc_rx_src_ready_n,
  // user flow control receive, stream side out
  output logic [stream_shim_pkg::UFC_W-1:0] m_axis_ufc_rx_tdata,
  output logic [stream_shim_pkg::UFC_BYTES-1:0] m_axis_ufc_rx_tkeep,
  output logic m_axis_ufc_rx_tlast,
  output logic m_axis_ufc_rx_tvalid
);

  localparam int TXW = DATA_W + REMAINDER_W + 2;

  if (DATA_BYTES < 2 || (DATA_BYTES & (DATA_BYTES - 1)) != 0) begin : g_chk_data
    $error("data bytes must be a power of two, at least two");
  end
  if (UFC_BYTES < 2 || (UFC_BYTES & (UFC_BYTES - 1)) != 0) begin : g_chk_ufc
    $error("flow control bytes must be a power of two, at least two");
  end
  if (NFC_STOP_POS < NFC_PAUSE_POS + NFC_PAUSE_W || NFC_STOP_POS >= NFC_DATA_W) begin : g_chk_nfc
    $error("native flow word layout does not fit");
  end
  if (UK_BLK_POS < UK_PAY_POS + UK_PAY_W || UK_BLK_POS + UK_BLK_W > UK_DATA_W) begin : g_chk_uk
    $error("user control word layout does not fit");
  end

  // count of valid bytes minus one, keep is contiguous from byte zero
  function automatic logic [REMAINDER_W-1:0] keep_to_remainder(input logic [DATA_BYTES-1:0] k);
    logic [REMAINDER_W:0] n;
    n = '0;
    for (int i = 0; i < DATA_BYTES; i++) begin
      n = n + {{REMAINDER_W{1'b0}}, k[i]};
    end
    n = n - 1'b1;
    return n[REMAINDER_W-1:0];
  endfunction : keep_to_remainder

  // low bytes up to and including the remainder position are valid
  function automatic logic [DATA_BYTES-1:0] remainder_to_keep(input logic [REMAINDER_W-1:0] r);
    logic [REMAINDER_W:0] idx;
    logic [DATA_BYTES-1:0] k;
    idx = '0;
    k = '0;
    for (int i = 0; i < DATA_BYTES; i++) begin
      k[i] = (idx <= {1'b0, r});
      idx = idx + 1'b1;
    end
    return k;
  endfunction : remainder_to_keep

  function automatic logic [UFC_BYTES-1:0] ufc_remainder_to_keep(
    input logic [UFC_REMAINDER_W-1:0] r);
    logic [UFC_REMAINDER_W:0] idx;
    logic [UFC_BYTES-1:0] k;
    idx = '0;
    k = '0;
    for (int i = 0; i < UFC_BYTES; i++) begin
      k[i] = (idx <= {1'b0, r});
      idx = idx + 1'b1;
    end
    return k;
  endfunction : ufc_remainder_to_keep

  logic in_frame_q;
  logic tx_accept;
  logic tx_sof;
  logic [TXW-1:0] tx_word;
  logic [TXW-1:0] tx_word_q;
  logic [NFC_PAUSE_W:0] nfc_word;
  logic [NFC_PAUSE_W:0] nfc_word_q;
  logic [UK_PAY_W+UK_BLK_W-1:0] uk_word;
  logic [UK_PAY_W+UK_BLK_W-1:0] uk_word_q;

  // word taken on valid and ready
  assign tx_accept = s_axis_tx_tvalid & s_axis_tx_tready;
  assign tx_sof = ~in_frame_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_frame_q <= RST_IN_FRAME;
    end else if (tx_accept) begin
      in_frame_q <= ~s_axis_tx_tlast;
    end
  end

  assign tx_word = {~tx_sof, ~s_axis_tx_tlast, keep_to_remainder(s_axis_tx_tkeep),
                    s_axis_tx_tdata};

  frame_slice #(.W(TXW), .IN_LOW(1'b0), .OUT_LOW(1'b1)) u_tx_data (
    .clk(clk),
    .rst(rst),
    .in_valid(s_axis_tx_tvalid),
    .in_ready(s_axis_tx_tready),
    .in_data(tx_word),
    .out_valid(tx_src_ready_n),
    .out_ready(tx_dest_ready_n),
    .out_data(tx_word_q)
  );

  assign tx_data = tx_word_q[DATA_W-1:0];
  assign tx_remainder_count = tx_word_q[DATA_W +: REMAINDER_W];
  assign tx_eof_n = tx_word_q[DATA_W+REMAINDER_W];
  assign tx_sof_n = tx_word_q[DATA_W+REMAINDER_W+1];

  frame_slice #(.W(UFC_W), .IN_LOW(1'b0), .OUT_LOW(1'b1)) u_tx_ufc (
    .clk(clk),
    .rst(rst),
    .in_valid(s_axis_ufc_tx_tvalid),
    .in_ready(s_axis_ufc_tx_tready),
    .in_data(s_axis_ufc_tx_tdata),
    .out_valid(ufc_tx_src_ready_n),
    .out_ready(ufc_tx_dest_ready_n),
    .out_data(ufc_tx_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ufc_tx_req_n <= RST_ACTIVE_LOW_IDLE;
      ufc_tx_ms_q <= 8'h00;
    end else begin
      ufc_tx_req_n <= ~ufc_tx_req;
      ufc_tx_ms_q <= ufc_tx_ms;
    end
  end

  assign nfc_word = {s_axis_nfc_tx_tdata[NFC_STOP_POS],
                     s_axis_nfc_tx_tdata[NFC_PAUSE_POS +: NFC_PAUSE_W]};

  frame_slice #(.W(NFC_PAUSE_W + 1), .IN_LOW(1'b0), .OUT_LOW(1'b1)) u_tx_nfc (
    .clk(clk),
    .rst(rst),
    .in_valid(s_axis_nfc_tx_tvalid),
    .in_ready(s_axis_nfc_tx_tready),
    .in_data(nfc_word),
    .out_valid(nfc_tx_req_n),
    .out_ready(nfc_tx_ack_n),
    .out_data(nfc_word_q)
  );

  assign nfc_pause_count = nfc_word_q[NFC_PAUSE_W-1:0];
  assign flow_stop_request = nfc_word_q[NFC_PAUSE_W];

  assign uk_word = {s_axis_user_k_tdata[UK_BLK_POS +: UK_BLK_W],
                    s_axis_user_k_tdata[UK_PAY_POS +: UK_PAY_W]};

  frame_slice #(.W(UK_PAY_W + UK_BLK_W), .IN_LOW(1'b0), .OUT_LOW(1'b1)) u_tx_uk (
    .clk(clk),
    .rst(rst),
    .in_valid(s_axis_user_k_tvalid),
    .in_ready(s_axis_user_k_tready),
    .in_data(uk_word),
    .out_valid(user_k_src_ready_n),
    .out_ready(user_k_dest_ready_n),
    .out_data(uk_word_q)
  );

  assign user_k_data = uk_word_q[UK_PAY_W-1:0];
  assign user_block_number = uk_word_q[UK_PAY_W +: UK_BLK_W];

  always_ff @(posedge clk) begin
    if (rst) begin
      m_axis_rx_tvalid <= RST_ACTIVE_HIGH_IDLE;
      m_axis_rx_tlast <= RST_ACTIVE_HIGH_IDLE;
      m_axis_rx_tdata <= '0;
      m_axis_rx_tkeep <= '0;
    end else begin
      m_axis_rx_tvalid <= ~rx_src_ready_n;
      m_axis_rx_tlast <= ~rx_eof_n & ~rx_src_ready_n;
      m_axis_rx_tdata <= rx_data;
      m_axis_rx_tkeep <= rx_eof_n ? {DATA_BYTES{1'b1}} : remainder_to_keep(rx_remainder_count);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      m_axis_ufc_rx_tvalid <= RST_ACTIVE_HIGH_IDLE;
      m_axis_ufc_rx_tlast <= RST_ACTIVE_HIGH_IDLE;
      m_axis_ufc_rx_tdata <= '0;
      m_axis_ufc_rx_tkeep <= '0;
    end else begin
      m_axis_ufc_rx_tvalid <= ~ufc_rx_src_ready_n;
      m_axis_ufc_rx_tlast <= ~ufc_rx_eof_n & ~ufc_rx_src_ready_n;
      m_axis_ufc_rx_tdata <= ufc_rx_data;
      m_axis_ufc_rx_tkeep <= ufc_rx_eof_n ? {UFC_BYTES{1'b1}} :
                             ufc_remainder_to_keep(ufc_rx_remainder_count);
    end
  end

endmodule : stream_framing_shim

/* File: stream_sink_model.sv */
// far-side framing sink for every transmit shim path
// assumes stall comes from the bench on the clk rising edge
`timescale 1ns/1ps
module stream_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  output logic tx_dest_ready_n,
  output logic ufc_tx_dest_ready_n,
  output logic nfc_tx_ack_n,
  output logic user_k_dest_ready_n
);
  always_ff @(posedge clk) begin
    tx_dest_ready_n <= rst || stall;
  end
  assign ufc_tx_dest_ready_n = tx_dest_ready_n;
  assign nfc_tx_ack_n = tx_dest_ready_n;
  assign user_k_dest_ready_n = tx_dest_ready_n;
endmodule : stream_sink_model

/* File: stream_framing_shim_monitor.sv */
// checker for the stream/framing shim ports
// assumes one clk domain, rst synchronous active high
`timescale 1ns/1ps
module stream_framing_shim_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [63:0] s_axis_tx_tdata,
  input wire logic [7:0] s_axis_tx_tkeep,
  input wire logic s_axis_tx_tlast,
  input wire logic s_axis_tx_tvalid,
  input wire logic s_axis_tx_tready,
  input wire logic [63:0] tx_data,
  input wire logic [2:0] tx_remainder_count,
  input wire logic tx_sof_n,
  input wire logic tx_eof_n,
  input wire logic tx_src_ready_n,
  input wire logic tx_dest_ready_n,
  input wire logic [15:0] s_axis_nfc_tx_tdata,
  input wire logic s_axis_nfc_tx_tvalid,
  input wire logic s_axis_nfc_tx_tready,
  input wire logic [7:0] nfc_pause_count,
  input wire logic flow_stop_request,
  input wire logic nfc_tx_req_n,
  input wire logic nfc_tx_ack_n,
  input wire logic [2:0] rx_remainder_count,
  input wire logic rx_eof_n,
  input wire logic rx_src_ready_n,
  input wire logic [7:0] m_axis_rx_tkeep,
  input wire logic m_axis_rx_tlast,
  input wire logic m_axis_rx_tvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence tx_end_acc;
    !tx_src_ready_n && !tx_dest_ready_n && !tx_eof_n;
  endsequence
  sequence tx_mid_acc;
    !tx_src_ready_n && !tx_dest_ready_n && tx_eof_n;
  endsequence
  sequence tx_take;
    s_axis_tx_tvalid && s_axis_tx_tready && (tx_src_ready_n || !tx_dest_ready_n);
  endsequence
  a_sof_after_end: assert property (tx_end_acc ##1 !tx_src_ready_n |-> !tx_sof_n)
    else $error("start flag missing");
  a_sof_mid_frame: assert property (tx_mid_acc ##1 !tx_src_ready_n |-> tx_sof_n)
    else $error("start flag mid frame");
  a_tx_word_hold: assert property (!tx_src_ready_n && tx_dest_ready_n |=>
    !tx_src_ready_n && $stable(tx_data) && $stable(tx_eof_n) && $stable(tx_sof_n))
    else $error("stalled word changed");
  a_tx_word_map: assert property (tx_take |=> !tx_src_ready_n &&
    tx_data == $past(s_axis_tx_tdata) && tx_eof_n == !$past(s_axis_tx_tlast))
    else $error("tx word wrong");
  a_tx_rem_map: assert property (tx_take |=>
    tx_remainder_count == 3'($countones($past(s_axis_tx_tkeep)) - 1))
    else $error("remainder wrong");
  a_rx_valid_inv: assert property (!$past(rst) |-> m_axis_rx_tvalid == !$past(rx_src_ready_n))
    else $error("rx valid wrong");
  a_rx_last_map: assert property (!$past(rst) |->
    m_axis_rx_tlast == (!$past(rx_eof_n) && !$past(rx_src_ready_n)))
    else $error("rx last wrong");
  a_rx_keep_map: assert property (!rx_eof_n && !rx_src_ready_n |=>
    m_axis_rx_tkeep == 8'(8'hFF >> (3'd7 - $past(rx_remainder_count))))
    else $error("rx keep wrong");
  a_nfc_word_map: assert property (s_axis_nfc_tx_tvalid && s_axis_nfc_tx_tready &&
    (nfc_tx_req_n || !nfc_tx_ack_n) |=> !nfc_tx_req_n &&
    nfc_pause_count == $past(s_axis_nfc_tx_tdata[7:0]) &&
    flow_stop_request == $past(s_axis_nfc_tx_tdata[8]))
    else $error("nfc word wrong");
endmodule : stream_framing_shim_monitor
bind stream_framing_shim stream_framing_shim_monitor u_stream_framing_shim_monitor (.*);

/* File: stream_framing_shim_test.sv */
// self-checking bench for the stream/framing shim
// assumes the sink model as far side; all paths share one stimulus
`timescale 1ns/1ps
module stream_framing_shim_test;
  logic clk, rst, stall;
  logic [63:0] s_axis_tx_tdata, tx_data, s_axis_ufc_tx_tdata, ufc_tx_data, s_axis_user_k_tdata;
  logic [63:0] rx_data, m_axis_rx_tdata, ufc_rx_data, m_axis_ufc_rx_tdata;
  logic [7:0] s_axis_tx_tkeep, ufc_tx_ms, ufc_tx_ms_q, nfc_pause_count;
  logic [7:0] m_axis_rx_tkeep, m_axis_ufc_rx_tkeep;
  logic [2:0] tx_remainder_count, rx_remainder_count, ufc_rx_remainder_count;
  logic [15:0] s_axis_nfc_tx_tdata;
  logic [55:0] user_k_data;
  logic [3:0] user_block_number;
  logic s_axis_tx_tlast, s_axis_tx_tvalid, s_axis_tx_tready, tx_sof_n, tx_eof_n;
  logic tx_src_ready_n, tx_dest_ready_n, ufc_tx_req, s_axis_ufc_tx_tvalid, s_axis_ufc_tx_tready;
  logic ufc_tx_req_n, ufc_tx_src_ready_n, ufc_tx_dest_ready_n, s_axis_nfc_tx_tvalid;
  logic s_axis_nfc_tx_tready, flow_stop_request, nfc_tx_req_n, nfc_tx_ack_n;
  logic s_axis_user_k_tvalid, s_axis_user_k_tready, user_k_src_ready_n, user_k_dest_ready_n;
  logic rx_eof_n, rx_src_ready_n, m_axis_rx_tlast, m_axis_rx_tvalid;
  logic ufc_rx_eof_n, ufc_rx_src_ready_n, m_axis_ufc_rx_tlast, m_axis_ufc_rx_tvalid;
  int n_errors = 0;
  int check_count = 0;
  // rows: keep and last in, remainder out
  // contiguous nonempty keep
  logic [7:0] kp [7] = '{8'hFF, 8'hFF, 8'h01, 8'h0F, 8'hFF, 8'h7F, 8'h3F};
  logic lt [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [2:0] rm [7] = '{3'd7, 3'd7, 3'd0, 3'd3, 3'd7, 3'd6, 3'd5};
  stream_framing_shim u_stream_framing_shim (.*);
  stream_sink_model u_stream_sink_model (.*);
  assign s_axis_ufc_tx_tdata = s_axis_tx_tdata;
  assign s_axis_user_k_tdata = s_axis_tx_tdata;
  assign rx_data = s_axis_tx_tdata;
  assign ufc_rx_data = s_axis_tx_tdata;
  assign s_axis_nfc_tx_tdata = s_axis_tx_tdata[15:0];
  assign ufc_tx_ms = s_axis_tx_tdata[7:0];
  assign ufc_tx_req = s_axis_tx_tvalid;
  assign s_axis_ufc_tx_tvalid = s_axis_tx_tvalid;
  assign s_axis_nfc_tx_tvalid = s_axis_tx_tvalid;
  assign s_axis_user_k_tvalid = s_axis_tx_tvalid;
  assign rx_src_ready_n = !s_axis_tx_tvalid;
  assign ufc_rx_src_ready_n = rx_src_ready_n;
  assign rx_eof_n = !s_axis_tx_tlast;
  assign ufc_rx_eof_n = rx_eof_n;
  assign rx_remainder_count = 3'($countones(s_axis_tx_tkeep) - 1);
  assign ufc_rx_remainder_count = rx_remainder_count;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [63:0] dat(input int k);
    return 64'h9E3779B97F4A7C15 * 64'(k + 1);
  endfunction : dat
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic check_row(input int k);
    logic [63:0] dt;
    logic [7:0] ek;
    dt = dat(k);
    ek = lt[k] ? kp[k] : 8'hFF;
    chk(tx_data === dt && tx_eof_n === !lt[k] && tx_src_ready_n === 1'b0, "tx word");
    chk(tx_remainder_count === rm[k] && tx_sof_n === !(k == 0 || lt[k-1]), "sof rem");
    chk(nfc_pause_count === dt[7:0] && flow_stop_request === dt[8] && !nfc_tx_req_n, "nfc");
    chk(user_k_data === dt[55:0] && user_block_number === dt[59:56], "user k");
    chk(ufc_tx_data === dt && ufc_tx_src_ready_n === 1'b0 && ufc_tx_req_n === 1'b0, "ufc");
    chk(m_axis_rx_tdata === dt && m_axis_rx_tvalid === 1'b1 && m_axis_rx_tlast === lt[k], "rx");
    chk(m_axis_rx_tkeep === ek && m_axis_ufc_rx_tkeep === ek && m_axis_ufc_rx_tvalid, "keep");
    chk(ufc_tx_ms_q === dt[7:0] && user_k_src_ready_n === 1'b0, "ms");
    chk(m_axis_ufc_rx_tdata === dt && m_axis_ufc_rx_tlast === lt[k], "ufc rx");
  endtask : check_row
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    int w;
    rst = 1'b1;
    stall = 1'b0;
    s_axis_tx_tvalid = 1'b0;
    s_axis_tx_tdata = '0;
    s_axis_tx_tkeep = 8'hFF;
    s_axis_tx_tlast = 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(s_axis_tx_tready && tx_src_ready_n && nfc_tx_req_n && !m_axis_rx_tvalid, "reset");
    $display("test reset done");
    @(posedge clk) rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      s_axis_tx_tvalid <= 1'b1;
      s_axis_tx_tdata <= dat(k);
      s_axis_tx_tkeep <= kp[k];
      s_axis_tx_tlast <= lt[k];
      #1 if (k > 0) check_row(k - 1);
    end
    @(posedge clk) s_axis_tx_tvalid <= 1'b0;
    #1 check_row(6);
    $display("test table done");
    @(posedge clk) stall <= 1'b1;
    @(posedge clk);
    s_axis_tx_tvalid <= 1'b1;
    s_axis_tx_tdata <= dat(8);
    s_axis_tx_tkeep <= 8'hFF;
    s_axis_tx_tlast <= 1'b0;
    @(posedge clk);
    s_axis_tx_tdata <= dat(9);
    s_axis_tx_tkeep <= 8'h03;
    s_axis_tx_tlast <= 1'b1;
    @(posedge clk) s_axis_tx_tvalid <= 1'b0;
    @(posedge clk);
    #1 chk(s_axis_tx_tready === 1'b0 && tx_data === dat(8), "stall hold");
    chk(!s_axis_ufc_tx_tready && !s_axis_nfc_tx_tready && !s_axis_user_k_tready, "stall rdy");
    @(posedge clk) stall <= 1'b0;
    for (w = 0; w < 8; w++) begin
      @(posedge clk);
      #1 if (tx_data === dat(9)) break;
    end
    if (w == 8) begin
      n_errors++;
      $display("ERROR %0t skid word never shown", $time);
    end else begin
      chk(tx_sof_n === 1'b1 && tx_eof_n === 1'b0 && tx_remainder_count === 3'd1, "skid");
      @(posedge clk);
      #1 chk(tx_src_ready_n === 1'b1 && s_axis_tx_tready === 1'b1, "drain");
      chk(s_axis_ufc_tx_tready && s_axis_nfc_tx_tready && s_axis_user_k_tready, "drain rdy");
      chk(m_axis_rx_tvalid === 1'b0 && m_axis_ufc_rx_tvalid === 1'b0, "rx idle");
      $display("test stall done");
      @(posedge clk);
      s_axis_tx_tvalid <= 1'b1;
      s_axis_tx_tdata <= dat(10);
      s_axis_tx_tkeep <= 8'hFF;
      s_axis_tx_tlast <= 1'b0;
      @(posedge clk);
      s_axis_tx_tvalid <= 1'b0;
      rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      #1 chk(tx_src_ready_n && s_axis_tx_tready && ufc_tx_req_n && !m_axis_rx_tvalid, "mid reset");
      @(posedge clk);
      s_axis_tx_tvalid <= 1'b1;
      s_axis_tx_tdata <= dat(11);
      s_axis_tx_tlast <= 1'b1;
      @(posedge clk) s_axis_tx_tvalid <= 1'b0;
      #1 chk(tx_data === dat(11) && tx_sof_n === 1'b0 && tx_src_ready_n === 1'b0, "reset sof");
      $display("test mid reset done");
    end
    test_done();
  end
endmodule : stream_framing_shim_test
